// ### design/adc_result_and_retry_regs.sv
// result registers and the fault auto-retry bits of the control register
// register port driven by a serial-bus front end; conversions from the converter
`timescale 1ns/1ps
`default_nettype none
module adc_result_and_retry_regs
	import adc_regs_pkg::*;
#(
	parameter logic oc_retry_reset = 1'b0
)(
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       reg_write,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            reg_hit,
	input  wire logic       test_mode,
	input  wire logic       conv_valid,
	input  wire chan_type   conv_channel,
	input  wire logic [9:0] conv_data,
	input  wire chan_type   bcast_channel,
	output logic      [1:0] bcast_label,
	output logic      [9:0] bcast_data,
	output logic            oc_retry_en,
	output logic            uv_retry_en,
	output logic            ov_retry_en
);
	logic [2:0] retry_ff;
	logic [9:0] sense_ff;
	logic [9:0] aux2_ff;
	logic [9:0] aux1_ff;
	logic [1:0] label_ff;
	logic [9:0] bdata_ff;
	logic       conv_take;

	function automatic logic [7:0] low_byte(input logic [9:0] v);
		return {v[1:0], low_pad};
	endfunction

	function automatic logic [9:0] wr_high(input logic [9:0] v, input logic [7:0] d);
		return {d, v[1:0]};
	endfunction

	assign conv_take = conv_valid && !test_mode;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			retry_ff[bit_oc_retry] <= oc_retry_reset;
			retry_ff[bit_uv_retry] <= uv_retry_reset;
			retry_ff[bit_ov_retry] <= ov_retry_reset;
		end
		else if (reg_write && reg_addr == off_control)
		begin
			retry_ff <= reg_wdata[2:0];
		end
	end
	assign oc_retry_en = retry_ff[bit_oc_retry];
	assign uv_retry_en = retry_ff[bit_uv_retry];
	assign ov_retry_en = retry_ff[bit_ov_retry];

	// whole word stored at once; host writes only in test
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			sense_ff <= result_reset;
			aux2_ff  <= result_reset;
			aux1_ff  <= result_reset;
		end
		else if (conv_take)
		begin
			unique case (conv_channel)
				chan_sense: sense_ff <= conv_data;
				chan_aux2:  aux2_ff  <= conv_data;
				chan_aux1:  aux1_ff  <= conv_data;
				default:    sense_ff <= sense_ff;
			endcase
		end
		else if (reg_write && test_mode)
		begin
			// low writes keep only bits 7:6
			unique case (reg_addr)
				off_sense_high: sense_ff <= wr_high(sense_ff, reg_wdata);
				off_sense_low:  sense_ff[1:0] <= reg_wdata[7:6];
				off_aux2_high:  aux2_ff <= wr_high(aux2_ff, reg_wdata);
				off_aux2_low:   aux2_ff[1:0] <= reg_wdata[7:6];
				off_aux1_high:  aux1_ff <= wr_high(aux1_ff, reg_wdata);
				off_aux1_low:   aux1_ff[1:0] <= reg_wdata[7:6];
				default:        sense_ff <= sense_ff;
			endcase
		end
	end

	always_comb
	begin
		reg_hit = 1'b1;
		unique case (reg_addr)
			off_control:    reg_rdata = {5'h00, retry_ff};
			off_sense_high: reg_rdata = sense_ff[9:2];
			off_sense_low:  reg_rdata = low_byte(sense_ff);
			off_aux2_high:  reg_rdata = aux2_ff[9:2];
			off_aux2_low:   reg_rdata = low_byte(aux2_ff);
			off_aux1_high:  reg_rdata = aux1_ff[9:2];
			off_aux1_low:   reg_rdata = low_byte(aux1_ff);
			default:
			begin
				reg_rdata = 8'h00;
				reg_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			label_ff <= label_sense;
			bdata_ff <= result_reset;
		end
		else
		begin
			unique case (bcast_channel)
				chan_aux2:
				begin
					label_ff <= label_aux2;
					bdata_ff <= aux2_ff;
				end
				chan_aux1:
				begin
					label_ff <= label_aux1;
					bdata_ff <= aux1_ff;
				end
				default:
				begin
					label_ff <= label_sense;
					bdata_ff <= sense_ff;
				end
			endcase
		end
	end
	assign bcast_label = label_ff;
	assign bcast_data  = bdata_ff;

	label_map_a: assert property (@(posedge clock) disable iff (reset)
		bcast_channel == chan_aux1 |=> bcast_label == label_aux1 && bcast_data == $past(aux1_ff))
		else $error("broadcast label wrong");

	label_sense_a: assert property (@(posedge clock) disable iff (reset)
		bcast_channel == chan_sense |=> bcast_label == label_sense && bcast_data == $past(sense_ff))
		else $error("current broadcast label wrong");

	label_aux2_a: assert property (@(posedge clock) disable iff (reset)
		bcast_channel == chan_aux2 |=> bcast_label == label_aux2 && bcast_data == $past(aux2_ff))
		else $error("second auxiliary broadcast label wrong");

	test_hold_a: assert property (@(posedge clock) disable iff (reset)
		test_mode && !reg_write |=> $stable(sense_ff) && $stable(aux1_ff))
		else $error("result moved in test mode");

	no_host_wr_a: assert property (@(posedge clock) disable iff (reset)
		!test_mode && !conv_valid |=> $stable(aux2_ff))
		else $error("result written outside test");

	test_write_a: assert property (@(posedge clock) disable iff (reset)
		test_mode && reg_write && reg_addr == off_aux2_high |=> aux2_ff[9:2] == $past(reg_wdata))
		else $error("test mode write lost");

	aux2_halt_a: assert property (@(posedge clock) disable iff (reset)
		test_mode && !reg_write |=> $stable(aux2_ff))
		else $error("second auxiliary moved in test mode");

	low_zero_a: assert property (@(posedge clock) disable iff (reset)
		reg_addr == off_aux2_low |-> reg_rdata[5:0] == low_pad)
		else $error("reserved bits not zero");

	sense_pad_a: assert property (@(posedge clock) disable iff (reset)
		reg_addr == off_sense_low |-> reg_rdata[5:0] == low_pad)
		else $error("current reserved bits not zero");

	aux1_pad_a: assert property (@(posedge clock) disable iff (reset)
		reg_addr == off_aux1_low |-> reg_rdata[5:0] == low_pad)
		else $error("first auxiliary reserved bits not zero");

	whole_word_a: assert property (@(posedge clock) disable iff (reset)
		conv_take && conv_channel == chan_sense |=> sense_ff == $past(conv_data))
		else $error("result halves torn");

	aux2_word_a: assert property (@(posedge clock) disable iff (reset)
		conv_take && conv_channel == chan_aux2 |=> aux2_ff == $past(conv_data))
		else $error("second auxiliary halves torn");

	aux1_word_a: assert property (@(posedge clock) disable iff (reset)
		conv_take && conv_channel == chan_aux1 |=> aux1_ff == $past(conv_data))
		else $error("first auxiliary halves torn");

	sense_read_a: assert property (@(posedge clock) disable iff (reset)
		reg_addr == off_sense_high |-> reg_rdata == sense_ff[9:2])
		else $error("current high byte wrong");

	sense_low_a: assert property (@(posedge clock) disable iff (reset)
		reg_addr == off_sense_low |-> reg_rdata[7:6] == sense_ff[1:0])
		else $error("current low bits wrong");

	aux2_read_a: assert property (@(posedge clock) disable iff (reset)
		reg_addr == off_aux2_high |-> reg_rdata == aux2_ff[9:2])
		else $error("second auxiliary high byte wrong");

	aux2_low_a: assert property (@(posedge clock) disable iff (reset)
		reg_addr == off_aux2_low |-> reg_rdata[7:6] == aux2_ff[1:0])
		else $error("second auxiliary low bits wrong");

	aux1_read_a: assert property (@(posedge clock) disable iff (reset)
		reg_addr == off_aux1_high |-> reg_rdata == aux1_ff[9:2])
		else $error("first auxiliary high byte wrong");

	aux1_low_a: assert property (@(posedge clock) disable iff (reset)
		reg_addr == off_aux1_low |-> reg_rdata[7:6] == aux1_ff[1:0])
		else $error("first auxiliary low bits wrong");

	addr_hit_a: assert property (@(posedge clock) disable iff (reset)
		reg_hit == (reg_addr >= off_control && reg_addr <= off_aux1_low))
		else $error("register hit wrong");

	oc_write_a: assert property (@(posedge clock) disable iff (reset)
		reg_write && reg_addr == off_control |=> oc_retry_en == $past(reg_wdata[2]))
		else $error("overcurrent retry not written");

	oc_reset_a: assert property (@(posedge clock)
		reset |=> oc_retry_en == oc_retry_reset)
		else $error("overcurrent retry default wrong");

	oc_hold_a: assert property (@(posedge clock) disable iff (reset)
		!(reg_write && reg_addr == off_control) |=> $stable(oc_retry_en))
		else $error("overcurrent retry changed");

	ctrl_read_a: assert property (@(posedge clock) disable iff (reset)
		reg_addr == off_control |-> reg_rdata == {5'h00, oc_retry_en, uv_retry_en, ov_retry_en})
		else $error("control readback wrong");

	uv_reset_a: assert property (@(posedge clock)
		reset |=> uv_retry_en && ov_retry_en)
		else $error("retry default wrong");

	uv_write_a: assert property (@(posedge clock) disable iff (reset)
		reg_write && reg_addr == off_control |=> uv_retry_en == $past(reg_wdata[bit_uv_retry]))
		else $error("undervoltage retry not written");

	uv_hold_a: assert property (@(posedge clock) disable iff (reset)
		!(reg_write && reg_addr == off_control) |=> $stable(uv_retry_en))
		else $error("undervoltage retry changed");

	ov_hold_a: assert property (@(posedge clock) disable iff (reset)
		!(reg_write && reg_addr == off_control) |=> $stable(ov_retry_en))
		else $error("overvoltage retry changed");

	ov_write_a: assert property (@(posedge clock) disable iff (reset)
		reg_write && reg_addr == off_control |=> ov_retry_en == $past(reg_wdata[bit_ov_retry]))
		else $error("overvoltage retry not written");

	conv_c: cover property (@(posedge clock) disable iff (reset) conv_take);
	test_wr_c: cover property (@(posedge clock) disable iff (reset) test_mode && reg_write);
	bcast_c: cover property (@(posedge clock) disable iff (reset) bcast_channel == chan_aux2);
	ctrl_wr_c: cover property (@(posedge clock) disable iff (reset) reg_write && reg_addr == off_control);
	aux1_bcast_c: cover property (@(posedge clock) disable iff (reset) bcast_channel == chan_aux1);
endmodule
`default_nettype wire

// ### design/adc_regs_pkg.sv
// constants for the result and retry register slice
// shared by the register slice and its surroundings
package adc_regs_pkg;
	localparam logic [7:0] off_control      = 8'h03;
	localparam logic [7:0] off_sense_high   = 8'h04;
	localparam logic [7:0] off_sense_low    = 8'h05;
	localparam logic [7:0] off_aux2_high    = 8'h06;
	localparam logic [7:0] off_aux2_low     = 8'h07;
	localparam logic [7:0] off_aux1_high    = 8'h08;
	localparam logic [7:0] off_aux1_low     = 8'h09;
	localparam int         bit_ov_retry     = 0;
	localparam int         bit_uv_retry     = 1;
	localparam int         bit_oc_retry     = 2;
	localparam int         bit_test_mode    = 5;
	localparam logic       uv_retry_reset   = 1'b1;
	localparam logic       ov_retry_reset   = 1'b1;
	localparam logic [9:0] result_reset     = 10'h000;
	localparam logic [1:0] label_sense      = 2'h0;
	localparam logic [1:0] label_aux2       = 2'h1;
	localparam logic [1:0] label_aux1       = 2'h2;
	localparam logic [5:0] low_pad          = 6'h00;
	typedef enum logic [1:0] {
		chan_sense = 2'b00,
		chan_aux2  = 2'b01,
		chan_aux1  = 2'b10
	} chan_type;
endpackage

// ### verification/conv_source.sv
// converter stand-in that hands one result per request
// assumes requests are raised just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module conv_source
	import adc_regs_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       go,
	input  wire chan_type   chan,
	input  wire logic [9:0] value,
	output logic            conv_valid,
	output chan_type        conv_channel,
	output logic      [9:0] conv_data
);
	// idle data is inverted so a stale result never looks fresh
	always_ff @(posedge clock)
	begin
		conv_valid <= go;
		conv_channel <= chan;
		conv_data <= go ? value : ~value;
	end
endmodule
`default_nettype wire

// ### verification/tb.sv
// self-checking bench for the result and retry register slice
// assumes the converter stand-in of conv_source.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import adc_regs_pkg::*;
	logic           clock = 0;
	logic           reset = 1;
	logic           reg_write = 0;
	logic           test_mode = 0;
	logic           go = 0;
	logic     [7:0] reg_addr = 8'h00;
	logic     [7:0] reg_wdata = 8'h00;
	logic     [7:0] reg_rdata;
	logic           reg_hit;
	logic     [9:0] value = 10'h000;
	logic     [9:0] conv_data;
	logic     [9:0] bcast_data;
	logic     [9:0] last [3] = '{10'h000, 10'h000, 10'h000};
	logic     [1:0] bcast_label;
	logic     [1:0] lab [3] = '{label_sense, label_aux2, label_aux1};
	logic     [2:0] retry;
	logic           oc_latch;
	logic           conv_valid;
	chan_type       chan = chan_sense;
	chan_type       conv_channel;
	chan_type       bcast_channel = chan_sense;
	int             seed = 32'h68C2;
	int             err_count = 0;
	int             total_checks = 0;
	int             cycles = 0;
	int             k;
	logic     [7:0] w;
	conv_source src (.clock(clock), .go(go), .chan(chan), .value(value),
		.conv_valid(conv_valid), .conv_channel(conv_channel), .conv_data(conv_data));
	adc_result_and_retry_regs #(.oc_retry_reset(1'b1)) uut (.clock(clock), .reset(reset),
		.reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_hit(reg_hit), .test_mode(test_mode),
		.conv_valid(conv_valid), .conv_channel(conv_channel), .conv_data(conv_data),
		.bcast_channel(bcast_channel), .bcast_label(bcast_label), .bcast_data(bcast_data),
		.oc_retry_en(retry[2]), .uv_retry_en(retry[1]), .ov_retry_en(retry[0]));
	// latch-off variant shares every input, only its overcurrent enable is compared, after reset and after each control write
	adc_result_and_retry_regs uut_latch (.clock(clock), .reset(reset),
		.reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(), .reg_hit(), .test_mode(test_mode),
		.conv_valid(conv_valid), .conv_channel(conv_channel), .conv_data(conv_data),
		.bcast_channel(bcast_channel), .bcast_label(), .bcast_data(),
		.oc_retry_en(oc_latch), .uv_retry_en(), .ov_retry_en());
	always #4 clock = ~clock;
	function automatic logic [7:0] off_hi(input int c);
		return off_sense_high + 8'(2 * c);
	endfunction
	function automatic logic [7:0] low_byte(input logic [9:0] d);
		return {d[1:0], low_pad};
	endfunction
	task check(input logic [18:0] seen, input logic [18:0] want);
		total_checks++;
		if (seen !== want)
		begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task rd(input logic [7:0] a, input logic h, input logic [7:0] want);
		@(posedge clock);
		#1 reg_addr = a;
		#1 check({reg_hit, reg_rdata}, {h, want});
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 reg_write = 1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clock);
		#1 reg_write = 0;
	endtask
	task conv(input int c, input logic [9:0] d);
		@(posedge clock);
		#1 go = 1;
		chan = chan_type'(c);
		value = d;
		if (!test_mode) last[c] = d;
		@(posedge clock);
		#1 go = 0;
		@(posedge clock);
	endtask
	task res(input int c);
		@(posedge clock);
		#1 bcast_channel = chan_type'(c);
		rd(off_hi(c), 1'b1, last[c][9:2]);
		rd(off_hi(c) + 8'h01, 1'b1, low_byte(last[c]));
		check({7'h00, bcast_label, bcast_data}, {7'h00, lab[c], last[c]});
	endtask
	task results;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			results;
		end
	end
	initial
	begin
		repeat (2) @(posedge clock);
		#1 reset = 0;
		check({16'h0000, retry}, {16'h0000, 3'b111});
		check({18'h00000, oc_latch}, 19'h00000);
		rd(off_control, 1'b1, 8'h07);
		rd(8'h0A, 1'b0, 8'h00);
		for (k = 0; k < 3; k++) res(k);
		repeat (24)
		begin
			k = {$random(seed)} % 3;
			conv(k, 10'($random(seed)));
			res(k);
		end
		conv(0, 10'h3FF);
		conv(1, 10'h001);
		conv(2, 10'h2AA);
		for (k = 0; k < 3; k++) res(k);
		repeat (8)
		begin
			w = 8'($random(seed));
			wr(off_control, w);
			check({16'h0000, retry}, {16'h0000, w[2:0]});
			check({18'h00000, oc_latch}, {18'h00000, w[2]});
			rd(off_control, 1'b1, {5'h00, w[2:0]});
		end
		@(posedge clock);
		#1 reset = 1;
		repeat (2) @(posedge clock);
		#1 reset = 0;
		last = '{10'h000, 10'h000, 10'h000};
		check({16'h0000, retry}, {16'h0000, 3'b111});
		check({18'h00000, oc_latch}, 19'h00000);
		for (k = 0; k < 3; k++) res(k);
		wr(off_aux1_high, 8'hFF);
		res(2);
		@(posedge clock);
		#1 test_mode = 1;
		conv(0, ~last[0]);
		res(0);
		wr(off_sense_high, 8'hA5);
		wr(off_sense_low, 8'hFF);
		wr(off_aux1_low, 8'h7F);
		last[0] = 10'h297;
		last[2][1:0] = 2'h1;
		res(0);
		res(2);
		wr(off_aux2_high, 8'h3C);
		wr(off_aux2_low, 8'h80);
		last[1] = 10'h0F2;
		res(1);
		#1 test_mode = 0;
		results;
	end
endmodule
`default_nettype wire
